// *** carrier_timer.sv ***
/*
 8-bit timer with period and duty compare registers: interval/square wave,
 PWM and carrier generator modes, one shared output pin and CPU registers.
 Assumes a single-cycle CPU write strobe, software that keeps to the
 programming constraints, and asynchronous pin and envelope-interrupt inputs.
*/
`timescale 1ns/1ps
`include "carrier_timer_regs.svh"

module carrier_timer
  import carrier_timer_pkg::*;
(
  input wire logic clock,               // 200 MHz peripheral clock
  input wire logic sys_rst,             // synchronous, active high
  input wire logic [15:0] regAddr,      // CPU address
  input wire logic regWrite,            // one-cycle write strobe
  input wire logic [7:0] regWdata,      // write data
  output logic [7:0] regRdata,          // read data, one cycle after address
  input wire logic lowSpeedOscClock,    // low-speed oscillator pin
  input wire logic envelopeTimerIrq,    // companion envelope timer interrupt
  output logic timerMatchIrq,           // one-cycle interrupt request
  input wire logic timerPinIn,          // shared pin level
  output logic timerPinOut,             // shared pin drive level
  output logic timerPinOeN              // low while the pin is driven
);

  timer_state_t q, d;
  reg_req_t req;
  logic tick;
  logic run;
  logic [1:0] mode;
  logic defLevel;
  logic [7:0] cmpVal;
  logic match;
  logic periodMatch;
  logic dutyMatch;
  logic dutyWrite;
  logic useDuty;

  assign req = '{addr: regAddr, wr: regWrite, wdata: regWdata};

  count_tick_gen u_tick (
    .clock(clock),
    .sys_rst(sys_rst),
    .clockSelect(q.mode[`BIT_CLKSEL_HI:`BIT_CLKSEL_LO]),
    .lowSpeedOscClock(lowSpeedOscClock),
    .tick(tick)
  );

  assign run = q.mode[`BIT_RUN_ENABLE];
  assign mode = q.mode[`BIT_MODE_HI:`BIT_MODE_LO];
  assign defLevel = q.mode[`BIT_DEFAULT_LEVEL];
  assign useDuty = (mode == `MODE_PWM) || (mode == `MODE_CARRIER);
  assign cmpVal = (q.sel == CMP_DUTY) ? q.dutyActive : q.period;
  // the first tick after start is swallowed to align to the count clock
  assign match = run && tick && q.started && (q.counter == cmpVal);
  assign periodMatch = match && (q.sel == CMP_PERIOD);
  assign dutyMatch = match && (q.sel == CMP_DUTY);
  assign dutyWrite = req.wr && (req.addr == `ADDR_DUTY_COMPARE);

  always_comb begin
    logic level;
    level = 1'b0;
    d = q;
    d.irq = 1'b0;
    d.env1 = envelopeTimerIrq;
    d.env2 = q.env1;
    d.envPrev = q.env2;
    d.pin1 = timerPinIn;
    d.pin2 = q.pin1;

    if (run && tick) begin
      if (!q.started) begin
        d.started = 1'b1;
      end else if (periodMatch) begin
        d.counter = 8'h00;
        d.outFf = !q.outFf;
        d.irq = 1'b1;
        if (useDuty) begin
          d.sel = CMP_DUTY;
        end
      end else if (dutyMatch) begin
        d.outFf = !q.outFf;
        d.sel = CMP_PERIOD;
        if (mode == `MODE_CARRIER) begin
          d.counter = 8'h00;
          d.irq = 1'b1;
        end else begin
          d.counter = q.counter + 8'h01;
        end
      end else begin
        d.counter = q.counter + 8'h01;
      end
    end

    if (!run) begin
      d.counter = 8'h00;
      d.started = 1'b0;
      d.sel = CMP_PERIOD;
      d.outFf = defLevel;
      d.pending = 1'b0;
    end

    // duty compare: shadow while counting, direct while stopped
    if (dutyWrite) begin
      d.dutyBuf = req.wdata;
      if (!run) begin
        d.dutyActive = req.wdata;
      end else begin
        d.pending = 1'b1;
      end
    end else if (dutyMatch && q.pending) begin
      d.dutyActive = q.dutyBuf;
      d.pending = 1'b0;
    end

    if (req.wr) begin
      case (req.addr)
        `ADDR_TIMER_MODE_CONTROL: d.mode = req.wdata;
        `ADDR_CARRIER_OUTPUT_CONTROL: d.carrierCtl = req.wdata[`BIT_REMOTE_MODE:`BIT_BUFFERED_DATA];
        `ADDR_PERIOD_COMPARE: begin
          // writes while counting are dropped rather than corrupting the period
          if (!run) begin
            d.period = req.wdata;
          end
        end
        `ADDR_PORT_ONE_DIRECTION: d.portDir = req.wdata;
        `ADDR_PORT_ONE_LATCH: d.portLatch = req.wdata;
        default: ;
      endcase
    end

    // envelope edge is held until the next count tick samples it
    if (tick) begin
      d.envPulse = q.envSeen;
      d.envSeen = 1'b0;
      if (q.envSeen && !q.envPulse) begin
        d.xferCnt = `XFER_TICKS;
      end else if (q.xferCnt != 2'h0) begin
        d.xferCnt = q.xferCnt - 2'h1;
        if (q.xferCnt == 2'h1) begin
          d.status = q.carrierCtl[`BIT_BUFFERED_DATA];
        end
      end
    end
    if (q.env2 && !q.envPrev) begin
      d.envSeen = 1'b1;
    end

    // gate on the next mode so enable and carrier gating never lag a mode write by a cycle
    if (d.mode[`BIT_MODE_HI:`BIT_MODE_LO] == `MODE_CARRIER) begin
      if (!d.status) begin
        level = 1'b0;
      end else if (d.carrierCtl[`BIT_REMOTE_MODE]) begin
        level = d.outFf;
      end else begin
        level = 1'b1;
      end
    end else begin
      level = d.outFf;
    end
    if (!d.mode[`BIT_OUTPUT_ENABLE]) begin
      level = 1'b0;
    end
    d.pinOut = level | d.portLatch[`BIT_TIMER_PIN];

    case (req.addr)
      `ADDR_TIMER_MODE_CONTROL: d.rdata = q.mode;
      `ADDR_CARRIER_OUTPUT_CONTROL: d.rdata = {5'h00, q.carrierCtl, q.status};
      `ADDR_PERIOD_COMPARE: d.rdata = q.period;
      `ADDR_DUTY_COMPARE: d.rdata = q.dutyBuf;
      `ADDR_PORT_ONE_DIRECTION: d.rdata = q.portDir;
      `ADDR_PORT_ONE_LATCH: d.rdata = {q.portLatch[7], q.pin2, q.portLatch[5:0]};
      default: d.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
      q.mode <= `RST_TIMER_MODE_CONTROL;
      q.period <= `RST_COMPARE;
      q.dutyActive <= `RST_COMPARE;
      q.dutyBuf <= `RST_COMPARE;
      q.portDir <= `RST_PORT_ONE_DIRECTION;
      q.portLatch <= `RST_PORT_ONE_LATCH;
      q.sel <= CMP_PERIOD;
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.rdata;
  assign timerMatchIrq = q.irq;
  assign timerPinOut = q.pinOut;
  assign timerPinOeN = q.portDir[`BIT_TIMER_PIN];

  sequence stopSeq;
    $fell(run);
  endsequence

  sequence periodHit;
    periodMatch && run;
  endsequence

  a_period_irq: assert property (@(posedge clock) disable iff (sys_rst)
    periodHit |=> timerMatchIrq && (q.counter == 8'h00))
    else $error("period match without interrupt and clear");

  a_period_toggle: assert property (@(posedge clock) disable iff (sys_rst)
    periodHit ##1 run |-> q.outFf != $past(q.outFf))
    else $error("period match did not toggle output");

  a_pwm_no_irq: assert property (@(posedge clock) disable iff (sys_rst)
    dutyMatch && (mode == `MODE_PWM) |=> !timerMatchIrq && (q.counter != 8'h00))
    else $error("pwm duty match raised interrupt or cleared counter");

  a_carrier_clear: assert property (@(posedge clock) disable iff (sys_rst)
    dutyMatch && (mode == `MODE_CARRIER) |=> timerMatchIrq && (q.counter == 8'h00))
    else $error("carrier duty match did not interrupt and clear");

  a_duty_conflict: assert property (@(posedge clock) disable iff (sys_rst)
    dutyWrite && dutyMatch |=> $stable(q.dutyActive))
    else $error("colliding duty write changed active value");

  a_stop_default: assert property (@(posedge clock) disable iff (sys_rst)
    stopSeq |=> (q.counter == 8'h00) && !timerMatchIrq && (q.outFf == defLevel))
    else $error("stop did not restore defaults");

  a_interval_ignore: assert property (@(posedge clock) disable iff (sys_rst)
    run && (mode == `MODE_INTERVAL) |-> q.sel == CMP_PERIOD)
    else $error("interval mode selected duty compare");

  a_start_mask: assert property (@(posedge clock) disable iff (sys_rst)
    run && !q.started |=> q.counter == 8'h00)
    else $error("counter moved on the masked start tick");

  a_count_step: assert property (@(posedge clock) disable iff (sys_rst)
    run && tick && q.started && !match |=> q.counter == $past(q.counter) + 8'h01)
    else $error("counter did not increment on tick");

  sequence dutyHit;
    dutyMatch && run;
  endsequence

  a_pwm_toggle: assert property (@(posedge clock) disable iff (sys_rst)
    dutyHit ##0 (mode == `MODE_PWM) |=> q.outFf != $past(q.outFf))
    else $error("pwm duty match did not toggle output");

  a_duty_select: assert property (@(posedge clock) disable iff (sys_rst)
    periodHit ##0 useDuty |=> q.sel == CMP_DUTY)
    else $error("period match did not switch to duty compare");

  a_period_select: assert property (@(posedge clock) disable iff (sys_rst)
    dutyHit |=> q.sel == CMP_PERIOD)
    else $error("duty match did not switch back to period compare");

  a_duty_load: assert property (@(posedge clock) disable iff (sys_rst)
    dutyHit ##0 (q.pending && !dutyWrite) |=> q.dutyActive == $past(q.dutyBuf))
    else $error("buffered duty not loaded on old match");

  a_run_buffer: assert property (@(posedge clock) disable iff (sys_rst)
    run && dutyWrite |=> $stable(q.dutyActive))
    else $error("running duty write changed active value");

  a_status_hold: assert property (@(posedge clock) disable iff (sys_rst)
    !(tick && (q.xferCnt == 2'h1)) |=> $stable(q.status))
    else $error("status bit changed outside a transfer");

  a_carrier_low: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == `MODE_CARRIER) && !q.status && !q.portLatch[`BIT_TIMER_PIN] |-> !timerPinOut)
    else $error("carrier output not low while disabled");

  a_carrier_level: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == `MODE_CARRIER) && q.status && !q.carrierCtl[`BIT_REMOTE_MODE]
      && q.mode[`BIT_OUTPUT_ENABLE] |-> timerPinOut)
    else $error("carrier output not high with remote mode off");

endmodule : carrier_timer

// *** carrier_timer_pkg.sv ***
/*
 Types shared by the timer and its count-clock generator.
 Assumes carrier_timer_regs.svh is available for the constants.
*/
package carrier_timer_pkg;

  typedef enum logic {CMP_PERIOD, CMP_DUTY} cmp_sel_t;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ls1;
    logic ls2;
    logic lsPrev;
    logic [11:0] div;
    logic [8:0] lsCnt;
    logic tick;
  } tick_state_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [2:1] carrierCtl;
    logic status;
    logic [7:0] period;
    logic [7:0] dutyActive;
    logic [7:0] dutyBuf;
    logic pending;
    logic [7:0] portDir;
    logic [7:0] portLatch;
    logic [7:0] counter;
    cmp_sel_t sel;
    logic started;
    logic outFf;
    logic irq;
    logic env1;
    logic env2;
    logic envPrev;
    logic envSeen;
    logic envPulse;
    logic [1:0] xferCnt;
    logic pin1;
    logic pin2;
    logic pinOut;
    logic [7:0] rdata;
  } timer_state_t;

endpackage : carrier_timer_pkg

// *** carrier_timer_regs.svh ***
/*
 Register addresses, field positions, reset values and prescaler exponents
 for the 8-bit interval / PWM / carrier timer.
 Assumes an 8-bit CPU data path with 16-bit addresses.
*/
`ifndef CARRIER_TIMER_REGS_SVH
`define CARRIER_TIMER_REGS_SVH

`define ADDR_PORT_ONE_LATCH 16'hFF01
`define ADDR_PORT_ONE_DIRECTION 16'hFF21
`define ADDR_TIMER_MODE_CONTROL 16'hFF6C
`define ADDR_CARRIER_OUTPUT_CONTROL 16'hFF6D
`define ADDR_PERIOD_COMPARE 16'hFF6E
`define ADDR_DUTY_COMPARE 16'hFF6F

`define RST_PORT_ONE_DIRECTION 8'hFF
`define RST_PORT_ONE_LATCH 8'h00
`define RST_TIMER_MODE_CONTROL 8'h00
`define RST_CARRIER_OUTPUT_CONTROL 8'h00
`define RST_COMPARE 8'h00

`define BIT_RUN_ENABLE 7
`define BIT_CLKSEL_HI 6
`define BIT_CLKSEL_LO 4
`define BIT_MODE_HI 3
`define BIT_MODE_LO 2
`define BIT_DEFAULT_LEVEL 1
`define BIT_OUTPUT_ENABLE 0
`define BIT_REMOTE_MODE 2
`define BIT_BUFFERED_DATA 1
`define BIT_ACTIVE_STATUS 0
`define BIT_TIMER_PIN 6

`define MODE_INTERVAL 2'h0
`define MODE_CARRIER 2'h1
`define MODE_PWM 2'h2

`define CLKSEL_PRS 3'h0
`define CLKSEL_PRS_4 3'h1
`define CLKSEL_PRS_16 3'h2
`define CLKSEL_PRS_64 3'h3
`define CLKSEL_PRS_4096 3'h4
`define CLKSEL_LS_128 3'h5
`define CLKSEL_LS_512 3'h6
`define CLKSEL_LS 3'h7

`define EXP_PRS_4 4'h2
`define EXP_PRS_16 4'h4
`define EXP_PRS_64 4'h6
`define EXP_PRS_4096 4'hC
`define EXP_LS_128 4'h7
`define EXP_LS_512 4'h9

`define XFER_TICKS 2'h2

`endif

// *** count_tick_gen.sv ***
/*
 Count-clock enable generator: one-cycle tick at the selected rate, from the
 peripheral clock prescaler or from edges of the low-speed oscillator pin.
 Assumes the oscillator is asynchronous and far slower than clock.
*/
`timescale 1ns/1ps
`include "carrier_timer_regs.svh"

module count_tick_gen
  import carrier_timer_pkg::*;
(
  input wire logic clock,               // 200 MHz peripheral clock
  input wire logic sys_rst,             // synchronous, active high
  input wire logic [2:0] clockSelect,   // count clock selection
  input wire logic lowSpeedOscClock,    // raw oscillator pin
  output logic tick                     // one-cycle count enable
);

  tick_state_t q, d;

  // true when the low k bits of v are all ones
  function automatic logic lowOnes(input logic [11:0] v, input logic [3:0] k);
    logic [12:0] m;
    m = (13'h0001 << k) - 13'h0001;
    return &(v | ~m[11:0]);
  endfunction : lowOnes

  always_comb begin
    logic lsEdge;
    lsEdge = 1'b0;
    d = q;
    d.ls1 = lowSpeedOscClock;
    d.ls2 = q.ls1;
    d.lsPrev = q.ls2;
    d.div = q.div + 12'h001;
    lsEdge = q.ls2 && !q.lsPrev;
    if (lsEdge) begin
      d.lsCnt = q.lsCnt + 9'h001;
    end
    case (clockSelect)
      `CLKSEL_PRS: d.tick = 1'b1;
      `CLKSEL_PRS_4: d.tick = lowOnes(q.div, `EXP_PRS_4);
      `CLKSEL_PRS_16: d.tick = lowOnes(q.div, `EXP_PRS_16);
      `CLKSEL_PRS_64: d.tick = lowOnes(q.div, `EXP_PRS_64);
      `CLKSEL_PRS_4096: d.tick = lowOnes(q.div, `EXP_PRS_4096);
      `CLKSEL_LS_128: d.tick = lsEdge && lowOnes({3'h0, q.lsCnt}, `EXP_LS_128);
      `CLKSEL_LS_512: d.tick = lsEdge && lowOnes({3'h0, q.lsCnt}, `EXP_LS_512);
      default: d.tick = lsEdge;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  a_fast_tick: assert property (@(posedge clock) disable iff (sys_rst)
    (clockSelect == `CLKSEL_PRS) [*2] |=> tick)
    else $error("undivided selection did not tick every cycle");

endmodule : count_tick_gen

// *** test_carrier_timer.sv ***
/*
 Self-checking testbench for carrier_timer: register access, interval, PWM,
 carrier gating and count clock selection, every setting written through the CPU write strobe.
 Assumes the register header and package of the design are compiled first.
*/
`timescale 1ns/1ps
`include "carrier_timer_regs.svh"

module test_carrier_timer;
  import carrier_timer_pkg::*;
  logic clock, sys_rst, regWrite, lowSpeedOscClock, envelopeTimerIrq, timerPinIn;
  logic [15:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic timerMatchIrq, timerPinOut, timerPinOeN;
  logic [1:0] code;
  int fail_count, n_tests, gap, g2, i, oscCnt;
  int divs[8] = '{1, 4, 16, 64, 4096, 1280, 5120, 10};

  carrier_timer uut (
    .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
    .regWdata(regWdata), .regRdata(regRdata), .lowSpeedOscClock(lowSpeedOscClock),
    .envelopeTimerIrq(envelopeTimerIrq), .timerMatchIrq(timerMatchIrq),
    .timerPinIn(timerPinIn), .timerPinOut(timerPinOut), .timerPinOeN(timerPinOeN)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // slow oscillator, one rising edge every 10 clocks
  always @(negedge clock) begin
    oscCnt <= (oscCnt == 9) ? 0 : oscCnt + 1;
    lowSpeedOscClock <= (oscCnt < 5);
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout_if(input int n);
    if (n >= 20000) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, 16'h0, 16'h1);
      close_out();
    end
  endtask : timeout_if

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clock);
    regAddr = a;
    @(negedge clock);
    check({8'h00, regRdata}, {8'h00, exp});
  endtask : rdc

  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (timerMatchIrq !== 1'b1 && n < 20000);
    timeout_if(n);
  endtask : wait_irq

  task automatic wait_pin(input logic v);
    int n;
    n = 0;
    while (timerPinOut !== v && n < 20000) begin
      @(negedge clock);
      n++;
    end
    timeout_if(n);
  endtask : wait_pin

  // cycles of one complete phase at level v
  task automatic pin_width(input logic v, output int n);
    wait_pin(~v);
    wait_pin(v);
    n = 0;
    while (timerPinOut === v && n < 20000) begin
      @(negedge clock);
      n++;
    end
    timeout_if(n);
  endtask : pin_width

  task automatic observe(output logic [1:0] c);
    c = 2'b00;
    repeat (16) begin
      @(negedge clock);
      c = c | (timerPinOut ? 2'b10 : 2'b01);
    end
  endtask : observe

  // stop, load compares (duty again before each restart), then run
  task automatic start(input logic [7:0] m, input logic [7:0] p, input logic [7:0] d);
    wr(`ADDR_TIMER_MODE_CONTROL, m & 8'h7F);
    wr(`ADDR_PERIOD_COMPARE, p);
    wr(`ADDR_DUTY_COMPARE, d);
    wr(`ADDR_TIMER_MODE_CONTROL, m);
  endtask : start

  initial begin
    sys_rst = 1'b1;
    regWrite = 1'b0;
    regAddr = 16'h0000;
    regWdata = 8'h00;
    envelopeTimerIrq = 1'b0;
    timerPinIn = 1'b0;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    rdc(`ADDR_TIMER_MODE_CONTROL, 8'h00);
    rdc(`ADDR_CARRIER_OUTPUT_CONTROL, 8'h00);
    rdc(`ADDR_PERIOD_COMPARE, 8'h00);
    rdc(`ADDR_DUTY_COMPARE, 8'h00);
    rdc(`ADDR_PORT_ONE_DIRECTION, 8'hFF);
    rdc(16'hFF70, 8'h00);
    check(timerPinOeN, 1'b1);
    wr(`ADDR_CARRIER_OUTPUT_CONTROL, 8'h07);
    rdc(`ADDR_CARRIER_OUTPUT_CONTROL, 8'h06);
    wr(`ADDR_PORT_ONE_DIRECTION, 8'hBF);
    check(timerPinOeN, 1'b0);
    timerPinIn = 1'b1;
    repeat (3) @(negedge clock);
    rdc(`ADDR_PORT_ONE_LATCH, 8'h40);
    timerPinIn = 1'b0;
    $display("test registers done");

    // duty compare loaded but ignored in interval mode
    start(8'h81, 8'h03, 8'h01);
    wait_irq(gap);
    wait_irq(gap);
    check(gap, 16'd4);
    @(negedge clock);
    check(timerMatchIrq, 1'b0);
    pin_width(1'b1, gap);
    check(gap, 16'd4);
    pin_width(1'b0, gap);
    check(gap, 16'd4);
    wr(`ADDR_PERIOD_COMPARE, 8'h09);
    wait_irq(gap);
    wait_irq(gap);
    check(gap, 16'd4);
    start(8'h83, 8'h03, 8'h00);
    wait_irq(gap);
    check((gap >= 4 && gap <= 7), 1'b1);
    repeat (2) @(negedge clock);
    check(timerPinOut, 1'b0);
    wr(`ADDR_TIMER_MODE_CONTROL, 8'h03);
    repeat (2) @(negedge clock);
    check(timerPinOut, 1'b1);
    check(timerMatchIrq, 1'b0);
    wr(`ADDR_TIMER_MODE_CONTROL, 8'h00);
    repeat (2) @(negedge clock);
    check(timerPinOut, 1'b0);
    $display("test interval done");

    start(8'h89, 8'h07, 8'h02);
    wait_irq(gap);
    wait_irq(gap);
    check(gap, 16'd8);
    pin_width(1'b1, gap);
    check(gap, 16'd3);
    wr(`ADDR_DUTY_COMPARE, 8'h04);
    rdc(`ADDR_DUTY_COMPARE, 8'h04);
    pin_width(1'b1, gap);
    pin_width(1'b1, gap);
    check(gap, 16'd5);
    $display("test pwm done");

    start(8'h85, 8'h03, 8'h01);
    for (i = 0; i < 4; i++) begin
      wr(`ADDR_CARRIER_OUTPUT_CONTROL, 8'(i << 1));
      @(negedge clock);
      envelopeTimerIrq = 1'b1;
      repeat (4) @(negedge clock);
      envelopeTimerIrq = 1'b0;
      repeat (12) @(negedge clock);
      rdc(`ADDR_CARRIER_OUTPUT_CONTROL, 8'((i << 1) | (i & 1)));
      observe(code);
      check(code, (i == 3) ? 2'b11 : (i == 1) ? 2'b10 : 2'b01);
    end
    // first wait only lines up with the interrupt train
    wait_irq(gap);
    wait_irq(gap);
    wait_irq(g2);
    check(gap + g2, 16'd6);
    pin_width(1'b1, gap);
    check(gap, 16'd2);
    $display("test carrier done");

    for (i = 0; i < 8; i++) begin
      start({1'b1, 3'(i), 4'h1}, 8'h01, 8'h00);
      wait_irq(gap);
      wait_irq(gap);
      check(gap, 16'(2 * divs[i]));
    end
    wr(`ADDR_TIMER_MODE_CONTROL, 8'h00);
    $display("test clock select done");
    close_out();
  end
endmodule : test_carrier_timer
